// >>> common/cac_pkg.sv
// shared constants for the comparator array control block
package cac_pkg;

    // ========================================================
    // array shape
    localparam int NCH   = 8;
    localparam int NPAIR = 4;
    localparam int SUT_W = 10;

    // ========================================================
    // register offsets (byte addresses)
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_SR   = 8'h04;
    localparam logic [7:0] OFS_ISR  = 8'h08;
    localparam logic [7:0] OFS_WIN  = 8'h0C;
    localparam logic [7:0] OFS_CONF = 8'h40;

    // ========================================================
    // field positions
    localparam int CTRL_EN     = 0;
    localparam int CTRL_EVTEN  = 1;
    localparam int CTRL_SOFTWARE_START_BIT = 2;
    localparam int CTRL_EVENT_START_BIT = 3;
    localparam int CTRL_SUT    = 8;
    localparam int SR_CCS      = 0;
    localparam int SR_RDY      = 8;
    localparam int SR_WRDY     = 16;
    localparam int CONF_MODE   = 0;
    localparam int CONF_IE     = 8;

    // ========================================================
    // reset values
    localparam logic [SUT_W-1:0] SUT_RST  = 10'h000;
    localparam logic [1:0]       MODE_RST = 2'h0;
    localparam logic [7:0]       ISR_RST  = 8'h00;
    localparam logic [3:0]       WIN_RST  = 4'h0;

    // ========================================================
    // channel modes
    typedef logic [1:0] cac_mode_t;
    localparam cac_mode_t MODE_OFF = 2'h0;
    localparam cac_mode_t MODE_CM  = 2'h1;
    localparam cac_mode_t MODE_UT  = 2'h2;
    localparam cac_mode_t MODE_ET  = 2'h3;

    // ========================================================
    // comparator clock derived from the bus clock
    localparam int CLK_PERIOD_NS  = 5;
    localparam int COMPARATOR_CLOCK_PERIOD_NS = 20;
    localparam int COMPARATOR_CLOCK_DIV       = COMPARATOR_CLOCK_PERIOD_NS / CLK_PERIOD_NS;

endpackage

// >>> rtl/cac_channel.sv
// one comparator channel: startup count, measurement and single-shot control
module cac_channel (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    tick,
    input  wire logic                    active,
    input  wire cac_pkg::cac_mode_t      mode,
    input  wire logic [cac_pkg::SUT_W-1:0] startup_time_field,
    input  wire logic                    start,
    input  wire logic                    raw,
    output logic                         ready,
    output logic                         ccs,
    output logic                         pending,
    output logic                         done
);

    typedef enum logic [1:0] {ST_OFF, ST_STARTUP, ST_RUN} cac_ch_state_t;

    cac_ch_state_t              state;
    cac_ch_state_t              next_state;
    logic [cac_pkg::SUT_W-1:0]  cnt;
    logic [cac_pkg::SUT_W-1:0]  next_cnt;
    logic                       next_ccs;
    logic                       next_pend;
    logic                       next_done;

    // ========================================================
    // next-state logic
    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        next_ccs   = ccs;
        next_pend  = pending | start;
        next_done  = 1'b0;
        if (mode == cac_pkg::MODE_CM) begin
            next_pend = 1'b0;
        end
        case (state)
            ST_OFF: begin
                next_cnt = '0;
                if (active) begin
                    next_state = ST_STARTUP;
                end
            end
            ST_STARTUP: begin
                if (cnt >= startup_time_field) begin
                    next_state = ST_RUN;
                end else if (tick) begin
                    next_cnt = cnt + 1'b1;
                end
            end
            ST_RUN: begin
                // compare only on a comparator clock edge
                if (tick && (mode == cac_pkg::MODE_CM || pending)) begin
                    next_ccs  = raw;
                    next_done = 1'b1;
                    next_pend = start; // a fresh start is kept
                end
            end
            default: next_state = ST_OFF;
        endcase
        // leaving the enabled set drops all channel state
        if (!active) begin
            next_state = ST_OFF;
            next_cnt   = '0;
            next_ccs   = 1'b0;
            next_pend  = 1'b0;
            next_done  = 1'b0; // no comparison is reported while disabled
        end
    end

    // ========================================================
    // state registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state   <= ST_OFF;
            cnt     <= '0;
            ccs     <= 1'b0;
            pending <= 1'b0;
            done    <= 1'b0;
        end else begin
            state   <= next_state;
            cnt     <= next_cnt;
            ccs     <= next_ccs;
            pending <= next_pend;
            done    <= next_done;
        end
    end

    assign ready = (state == ST_RUN);

endmodule // cac_channel

// >>> rtl/cac_top.sv
// comparator array control: apb registers, mode control and status
// Contract
// - window mode pairs channel 2k with 2k+1; normal mode ignores pairing
// - group A input k is channel 2k, group B input k is 2k+1
// - block runs only with global enable; each channel needs a nonzero mode
// - mode 0 off, 1 continuous, 2 software single, 3 event single
// - pairs in window mode coexist with independent normal channels
// - after enabling, count startup time on comparator clock before valid
// - ready flag low during startup, high once output usable
// - window result available only when both pair ready flags are set
// - continuous mode compares each comparator clock edge, tracks current state
// - continuous mode raises events each comparison until mode written zero
// - software start gives exactly one comparison after startup then stops
// - software start bit clears itself when its comparison completes
// - event with trigger enable sets event start bit, one comparison follows
// - event start bit clears itself when its comparison completes
// - with clocks removed in sleep, operation halts and later resumes
// - processor debug halt does not freeze comparisons
// - one combined interrupt request output
// - an event starts all event-mode channels together, others unaffected
// - compare output forced to zero while ready flag is zero
module cac_top (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic [7:0]            paddr,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [31:0]           pwdata,
    output logic                       pready,
    output logic [31:0]                prdata,
    output logic                       pslverr,
    input  wire logic [3:0]            group_a_result,
    input  wire logic [3:0]            group_b_result,
    input  wire logic                  peripheral_event,
    input  wire logic                  sleep_clock_off,
    output logic [cac_pkg::NCH-1:0]    comparator_enable,
    output logic [cac_pkg::NCH-1:0]    compare_output,
    output logic [cac_pkg::NPAIR-1:0]  window_ready,
    output logic [cac_pkg::NCH-1:0]    compare_done,
    output logic                       irq
);

    localparam int NCH = cac_pkg::NCH;
    localparam int DW  = $clog2(cac_pkg::COMPARATOR_CLOCK_DIV);

    logic                      en;
    logic                      evten;
    logic                      software_start_bit;
    logic                      event_start_bit;
    logic [cac_pkg::SUT_W-1:0] startup_time_field;
    cac_pkg::cac_mode_t        mode [NCH];
    logic [NCH-1:0]            ie;
    logic [3:0]                win;
    logic [NCH-1:0]            isr;
    logic [DW-1:0]             div;
    logic                      next_en;
    logic                      next_evten;
    logic                      next_software_start_bit;
    logic                      next_event_start_bit;
    logic [cac_pkg::SUT_W-1:0] next_sut;
    cac_pkg::cac_mode_t        next_mode [NCH];
    logic [NCH-1:0]            next_ie;
    logic [3:0]                next_win;
    logic [NCH-1:0]            next_isr;
    logic [DW-1:0]             next_div;
    logic [31:0]               next_prdata;
    logic                      tick;
    logic                      wr;
    logic                      hit;
    logic                      software_start_bit_go;
    logic                      event_start_bit_go;
    logic [NCH-1:0]            raw;
    logic [NCH-1:0]            active;
    logic [NCH-1:0]            is_ut;
    logic [NCH-1:0]            is_et;
    logic [NCH-1:0]            start;
    logic [NCH-1:0]            rdy;
    logic [NCH-1:0]            ccs;
    logic [NCH-1:0]            pend;
    logic [NCH-1:0]            done;

    // ========================================================
    // comparator clock enable
    // sleep stops the divider; every channel simply waits, keeping its
    // state, and carries on when the clock returns
    // halt and resume
    always_comb begin
        next_div = div;
        if (!sleep_clock_off) begin
            next_div = tick ? '0 : div + 1'b1;
        end
    end
    assign tick = !sleep_clock_off && (div == DW'(cac_pkg::COMPARATOR_CLOCK_DIV - 1));
    // no debug input: a debug halt never freezes comparisons, only sleep does

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div <= '0;
        end else begin
            div <= next_div;
        end
    end

    // ========================================================
    // channel array
    assign wr        = psel && penable && pwrite;
    assign software_start_bit_go = wr && (paddr == cac_pkg::OFS_CTRL) && en
                       && pwdata[cac_pkg::CTRL_SOFTWARE_START_BIT];
    assign event_start_bit_go = peripheral_event && en && evten;

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            // even channels from group A, odd from group B
            if (g % 2 == 0) begin : g_a
                assign raw[g] = group_a_result[g/2];
            end else begin : g_b
                assign raw[g] = group_b_result[g/2];
            end
            assign active[g] = en && (mode[g] != cac_pkg::MODE_OFF);
            assign is_ut[g]  = (mode[g] == cac_pkg::MODE_UT);
            assign is_et[g]  = (mode[g] == cac_pkg::MODE_ET);
            assign start[g]  = (is_ut[g] && software_start_bit_go) || (is_et[g] && event_start_bit_go);
            assign compare_output[g] = ccs[g] && rdy[g];
            cac_channel u_ch (
                .pclk    (pclk),
                .presetn (presetn),
                .tick    (tick),
                .active  (active[g]),
                .mode    (mode[g]),
                .startup_time_field     (startup_time_field),
                .start   (start[g]),
                .raw     (raw[g]),
                .ready   (rdy[g]),
                .ccs     (ccs[g]),
                .pending (pend[g]),
                .done    (done[g])
            );
        end
        for (g = 0; g < cac_pkg::NPAIR; g++) begin : g_pair
            // pair g is channels 2g and 2g+1, only in window mode
            assign window_ready[g] = win[g] && rdy[2*g] && rdy[2*g+1];
        end
    endgenerate

    // each pair switches to window mode on its own
    assign comparator_enable = active;
    assign compare_done      = done;

    // ========================================================
    // register file next values
    always_comb begin
        next_en     = en;
        next_evten  = evten;
        next_sut    = startup_time_field;
        next_ie     = ie;
        next_win    = win;
        next_mode   = mode;
        next_isr    = isr & ~(wr && paddr == cac_pkg::OFS_ISR ? pwdata[NCH-1:0] : '0);
        // clear once no software single is outstanding
        next_software_start_bit = software_start_bit && (|(pend & is_ut));
        // clear once no event single is outstanding
        next_event_start_bit = event_start_bit && (|(pend & is_et));
        if (wr && paddr == cac_pkg::OFS_CTRL) begin
            next_en    = pwdata[cac_pkg::CTRL_EN];
            next_evten = pwdata[cac_pkg::CTRL_EVTEN];
            next_sut   = pwdata[cac_pkg::CTRL_SUT +: cac_pkg::SUT_W];
        end
        if (wr && paddr == cac_pkg::OFS_WIN) begin
            next_win = pwdata[3:0];
        end
        for (int i = 0; i < NCH; i++) begin
            if (wr && paddr == cac_pkg::OFS_CONF + 8'(4*i)) begin
                next_mode[i] = pwdata[cac_pkg::CONF_MODE +: 2];
                next_ie[i]   = pwdata[cac_pkg::CONF_IE];
            end
        end
        if (software_start_bit_go) begin
            next_software_start_bit = 1'b1;
        end
        if (event_start_bit_go) begin
            next_event_start_bit = 1'b1;
        end
        // sticky comparison flags, set wins over clear
        next_isr = next_isr | done;
        if (!en) begin
            next_software_start_bit = 1'b0;
            next_event_start_bit = 1'b0;
        end
    end

    assign irq = |(isr & ie);

    // ========================================================
    // apb decode and read data, zero wait states
    always_comb begin
        hit = (paddr == cac_pkg::OFS_CTRL) || (paddr == cac_pkg::OFS_SR)
              || (paddr == cac_pkg::OFS_ISR) || (paddr == cac_pkg::OFS_WIN)
              || (paddr >= cac_pkg::OFS_CONF && paddr < cac_pkg::OFS_CONF + 8'h20
                  && paddr[1:0] == 2'h0);
        next_prdata = prdata;
        if (psel && !penable) begin
            next_prdata = 32'h0000_0000;
            case (paddr)
                cac_pkg::OFS_CTRL: begin
                    next_prdata[cac_pkg::CTRL_EN]     = en;
                    next_prdata[cac_pkg::CTRL_EVTEN]  = evten;
                    next_prdata[cac_pkg::CTRL_SOFTWARE_START_BIT] = software_start_bit;
                    next_prdata[cac_pkg::CTRL_EVENT_START_BIT] = event_start_bit;
                    next_prdata[cac_pkg::CTRL_SUT +: cac_pkg::SUT_W] = startup_time_field;
                end
                cac_pkg::OFS_SR: begin
                    next_prdata[cac_pkg::SR_CCS +: NCH] = compare_output;
                    next_prdata[cac_pkg::SR_RDY +: NCH] = rdy;
                    next_prdata[cac_pkg::SR_WRDY +: 4]  = window_ready;
                end
                cac_pkg::OFS_ISR: next_prdata[NCH-1:0] = isr;
                cac_pkg::OFS_WIN: next_prdata[3:0]     = win;
                default: begin
                    for (int i = 0; i < NCH; i++) begin
                        if (paddr == cac_pkg::OFS_CONF + 8'(4*i)) begin
                            next_prdata[cac_pkg::CONF_MODE +: 2] = mode[i];
                            next_prdata[cac_pkg::CONF_IE]        = ie[i];
                        end
                    end
                end
            endcase
        end
    end

    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hit; // unmapped answers with error

    // ========================================================
    // register storage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en     <= 1'b0;
            evten  <= 1'b0;
            software_start_bit <= 1'b0;
            event_start_bit <= 1'b0;
            startup_time_field    <= cac_pkg::SUT_RST;
            ie     <= '0;
            win    <= cac_pkg::WIN_RST;
            isr    <= cac_pkg::ISR_RST;
            prdata <= 32'h0000_0000;
            for (int i = 0; i < NCH; i++) begin
                mode[i] <= cac_pkg::MODE_RST;
            end
        end else begin
            en     <= next_en;
            evten  <= next_evten;
            software_start_bit <= next_software_start_bit;
            event_start_bit <= next_event_start_bit;
            startup_time_field    <= next_sut;
            ie     <= next_ie;
            win    <= next_win;
            isr    <= next_isr;
            prdata <= next_prdata;
            mode   <= next_mode;
        end
    end

    // ========================================================
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // helper: comparator clock edges seen during channel 0 startup
    logic [cac_pkg::SUT_W:0] ticks0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ticks0 <= '0;
        end else if (!active[0]) begin
            ticks0 <= '0;
        end else if (tick && !rdy[0]) begin
            ticks0 <= ticks0 + 1'b1;
        end
    end

    sequence seq_tick_gap;
        !tick [*3];
    endsequence

    chk_out_gated: assert property (~|(compare_output & ~rdy))
        else $error("compare output high without ready");
    chk_window_normal: assert property (~|(window_ready & ~win))
        else $error("window result in normal mode");
    chk_window_both: assert property (window_ready[0] |-> rdy[0] && rdy[1])
        else $error("window ready without both halves");
    chk_disable_idle: assert property (!en |=> ~|rdy)
        else $error("ready flag while disabled");
    chk_startup_len: assert property ($rose(rdy[0]) |-> ticks0 >= {1'b0, startup_time_field})
        else $error("channel ready before startup time");
    chk_ready_low: assert property (!active[0] |=> !rdy[0])
        else $error("ready flag set on inactive channel");
    chk_cm_follow: assert property (active[0] && rdy[0] && mode[0] == cac_pkg::MODE_CM && tick
                                    |=> ccs[0] == $past(raw[0]) && done[0])
        else $error("continuous compare missed a clock edge");
    chk_single_once: assert property (done[2] && is_ut[2] && !start[2] && !pend[2]
                                      |=> !pend[2] ##1 !done[2])
        else $error("single comparison repeated");
    chk_software_start_bit_clr: assert property (software_start_bit && !software_start_bit_go && ~|(pend & is_ut)
                                     |=> !software_start_bit)
        else $error("software start not cleared");
    chk_event_start_bit_set: assert property (event_start_bit_go |=> event_start_bit)
        else $error("event start bit not set");
    chk_event_start_bit_clr: assert property (event_start_bit && !event_start_bit_go && ~|(pend & is_et)
                                     |=> !event_start_bit)
        else $error("event start not cleared");
    chk_event_scope: assert property (~|(pend & ~$past(is_ut | is_et)))
        else $error("event start on non-single channel");
    chk_isr_sticky: assert property (done[0] |=> isr[0])
        else $error("comparison flag lost");
    chk_tick_rate: assert property (tick |=> seq_tick_gap)
        else $error("comparator clock faster than quarter rate");
    chk_sleep_halt: assert property (sleep_clock_off |-> !tick)
        else $error("comparator clock runs in sleep");

endmodule // cac_top

// >>> verification/cac_comp_model.sv
// behavioural model of the analog comparator array behind the block
module cac_comp_model (
    input  wire logic       pclk,
    input  wire logic [7:0] comparator_enable,
    input  wire logic [7:0] pat,
    output logic [3:0]      group_a_result,
    output logic [3:0]      group_b_result
);
    timeunit 1ns;
    timeprecision 100ps;
    // ========================================
    // unpowered outputs
    logic [7:0] junk = 8'h00;
    // a powered-down comparator gives no usable level, so it toggles
    always @(posedge pclk) junk <= ~junk;
    // ========================================
    // channel to input group mapping
    // even channel is group a, odd is group b
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            group_a_result[k] = comparator_enable[2*k] ? pat[2*k] : junk[2*k];
            group_b_result[k] = comparator_enable[2*k+1] ? pat[2*k+1] : junk[2*k+1];
        end
    end
endmodule // cac_comp_model

// >>> verification/test_cac_top.sv
// self-checking bench for the comparator array control block
module test_cac_top;
    timeunit 1ns;
    timeprecision 100ps;
    // ========================================
    // signals
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, peripheral_event = 1'b0, sleep_clock_off = 1'b0;
    logic        pready, pslverr, irq, er;
    logic [7:0]  paddr = 8'h00, pat = 8'h00, comparator_enable, compare_output, compare_done;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0]  group_a_result, group_b_result, window_ready;
    int          failures = 0, n_compared = 0;
    localparam logic [31:0] CTL  = 32'h0000_1401;  // enable, startup of 20 ticks
    localparam logic [7:0]  CONF = cac_pkg::OFS_CONF;
    // bus clock four times comparator clock
    always #2.5 pclk = ~pclk;
    cac_top dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .group_a_result(group_a_result),
        .group_b_result(group_b_result), .peripheral_event(peripheral_event),
        .sleep_clock_off(sleep_clock_off), .comparator_enable(comparator_enable),
        .compare_output(compare_output), .window_ready(window_ready),
        .compare_done(compare_done), .irq(irq));
    cac_comp_model far (.pclk(pclk), .comparator_enable(comparator_enable), .pat(pat),
        .group_a_result(group_a_result), .group_b_result(group_b_result));
    // ========================================
    // tasks
    // settle one edge's updates before looking at ports
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    // one apb transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic note(input string s);
        $display("test %s finished, mismatches so far %0d", s, failures);
    endtask
    task automatic print_verdict;
        $display("comparisons %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // ========================================
    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        cyc(20000);
        failures++;
        print_verdict();
    end
    // ========================================
    // tests
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, cac_pkg::OFS_SR, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h80, 32'h0);
        chk({31'h0, er}, 32'h1);
        note("reset");
        pat <= 8'h02;
        apb(1'b1, cac_pkg::OFS_CTRL, CTL);
        apb(1'b1, CONF, 32'h0000_0101);
        apb(1'b1, CONF + 8'h04, 32'h0000_0001);
        apb(1'b0, cac_pkg::OFS_SR, 32'h0);
        chk(rd, 32'h0);
        cyc(120);
        chk(comparator_enable, 8'h03);
        chk(compare_output, 8'h02);
        apb(1'b0, cac_pkg::OFS_SR, 32'h0);
        chk(rd, 32'h0000_0302);
        pat <= 8'h01;
        cyc(12);
        chk(compare_output, 8'h01);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, cac_pkg::OFS_WIN, 32'h1);
        cyc(3);
        chk(window_ready, 4'h1);
        @(posedge pclk);
        sleep_clock_off <= 1'b1;
        pat <= 8'h02;
        cyc(20);
        chk(compare_output, 8'h01);
        @(posedge pclk);
        sleep_clock_off <= 1'b0;
        cyc(12);
        chk(compare_output, 8'h02);
        apb(1'b1, CONF + 8'h04, 32'h0);
        cyc(3);
        chk(compare_output, 8'h00);
        chk(window_ready, 4'h0);
        note("continuous and window");
        apb(1'b1, CONF + 8'h08, 32'h2);
        pat <= 8'h04;
        apb(1'b1, cac_pkg::OFS_CTRL, 32'h0000_1405);
        do cyc(1); while (compare_done[2] !== 1'b1);
        pat <= 8'h00;
        cyc(20);
        chk(compare_output, 8'h04);
        apb(1'b0, cac_pkg::OFS_CTRL, 32'h0);
        chk(rd, CTL);
        note("software single");
        apb(1'b1, cac_pkg::OFS_CTRL, 32'h0000_1403);
        apb(1'b1, CONF + 8'h10, 32'h3);
        apb(1'b1, CONF + 8'h18, 32'h3);
        pat <= 8'h50;
        cyc(120);
        chk(compare_output, 8'h04);
        @(posedge pclk);
        peripheral_event <= 1'b1;
        @(posedge pclk);
        peripheral_event <= 1'b0;
        do cyc(1); while (compare_done[4] !== 1'b1);
        chk({31'h0, compare_done[6]}, 32'h1);
        cyc(3);
        chk(compare_output, 8'h54);
        apb(1'b0, cac_pkg::OFS_CTRL, 32'h0);
        chk(rd, 32'h0000_1403);
        note("event single");
        // block disabled before the run stops
        apb(1'b1, cac_pkg::OFS_CTRL, 32'h0);
        cyc(3);
        chk(comparator_enable, 8'h00);
        apb(1'b0, cac_pkg::OFS_SR, 32'h0);
        chk(rd, 32'h0);
        // starts while disabled must leave both start bits clear
        apb(1'b1, cac_pkg::OFS_CTRL, 32'h0000_0004);
        @(posedge pclk);
        peripheral_event <= 1'b1;
        @(posedge pclk);
        peripheral_event <= 1'b0;
        apb(1'b0, cac_pkg::OFS_CTRL, 32'h0);
        chk(rd, 32'h0);
        note("global disable");
        print_verdict();
    end
endmodule // test_cac_top
